// File: rcl_pkg.sv
/*
 * Package for the regulator configuration and lock register bank.
 * Assumes an 8-bit register port driven by the device's serial bus engine.
 */
package rcl_pkg;
   // ***************************************************************
   // Register map.
   // ***************************************************************
   localparam logic [7:0] BUCK_MODE_CONFIG_ADDR = 8'h81;
   localparam logic [7:0] LOCK_GROUP_MASK_ADDR  = 8'h83;
   localparam logic [7:0] LOCK_KEY_ADDR         = 8'h84;

   // Reset values; every register and lock flag starts cleared.
   localparam logic [7:0] BUCK_MODE_CONFIG_RST  = 8'h00;
   localparam logic [7:0] LOCK_GROUP_MASK_RST   = 8'h00;
   localparam logic [7:0] LOCK_STATE_RST        = 8'h00;

   // Key codes written to the lock key register.
   localparam logic [7:0] KEY_UNLOCK            = 8'h55;
   localparam logic [7:0] KEY_LOCK              = 8'haa;

   // ***************************************************************
   // Field positions of the buck mode register.
   // ***************************************************************
   localparam int BUCK_TWO_FORCED_DISCONTINUOUS_BIT       = 7;
   localparam int BUCK_ONE_FORCED_DISCONTINUOUS_BIT       = 6;
   localparam int BUCK_THREE_TRANSITION_VALLEY_CURRENT_BIT = 5;
   localparam int BUCK_TWO_TRANSITION_VALLEY_CURRENT_BIT  = 4;
   localparam int BUCK_ONE_TRANSITION_VALLEY_CURRENT_BIT  = 3;
   localparam int BUCK_THREE_NARROW_LOOP_BIT              = 2;
   localparam int BUCK_TWO_NARROW_LOOP_BIT                = 1;
   localparam int BUCK_ONE_NARROW_LOOP_BIT                = 0;

   // ***************************************************************
   // Function group bit positions, shared by mask and lock state.
   // ***************************************************************
   localparam int LDO_TWO_MASK_BIT     = 7;
   localparam int LDO_ONE_MASK_BIT     = 6;
   localparam int BUCKBOOST_MASK_BIT   = 5;
   localparam int BOOST_MASK_BIT       = 4;
   localparam int BUCK_THREE_MASK_BIT  = 3;
   localparam int BUCK_TWO_MASK_BIT    = 2;
   localparam int BUCK_ONE_MASK_BIT    = 1;
   localparam int CHARGER_MASK_BIT     = 0;

   // Register port request carried as one bundle.
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } rcl_req_t;

   // Per-buck control bits steering the converters.
   typedef struct packed {
      logic [1:0] forced_discontinuous;  // [1]=buck two, [0]=buck one.
      logic [2:0] valley_current_high;   // [2]=three .. [0]=one, 1 = 1000mA.
      logic [2:0] narrow_loop;           // [2]=three .. [0]=one, 1 = low bandwidth.
   } rcl_buck_ctrl_t;
endpackage

// File: rcl_lock_state.sv
/*
 * Lock state holder for the eight function groups.
 * Assumes the key write strobe is a one-cycle pulse from the register bank.
 */
`timescale 1ns/10ps
module rcl_lock_state (
   input  wire logic       mclk_i,
   input  wire logic       reset_i,
   input  wire logic       key_wr_i,
   input  wire logic [7:0] key_i,
   input  wire logic [7:0] mask_i,
   output logic      [7:0] locked_o
);
   logic [7:0] locked_r;
   logic [7:0] locked_nxt;
   wire        is_unlock = key_wr_i && (key_i == rcl_pkg::KEY_UNLOCK);
   wire        is_lock   = key_wr_i && (key_i == rcl_pkg::KEY_LOCK);

   // ***************************************************************
   // Lock update.
   // ***************************************************************
   // Masked groups keep their state; unknown codes change nothing.
   assign locked_nxt = is_lock   ? (locked_r | ~mask_i) :
                       is_unlock ? (locked_r & mask_i)  :
                       locked_r;

   // Holds the lock flags.
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         locked_r <= rcl_pkg::LOCK_STATE_RST;
      end else begin
         locked_r <= locked_nxt;
      end
   end

   assign locked_o = locked_r;

   // Masked groups never change on a key write.
   property p_masked_hold;
      @(posedge mclk_i) disable iff (reset_i)
         key_wr_i |=> ((locked_r & $past(mask_i)) == ($past(locked_r) & $past(mask_i)));
   endproperty
   a_masked_hold: assert property (p_masked_hold) else $error("Masked group changed lock state.");

   // Lock code sets every unmasked group.
   property p_lock_sets;
      @(posedge mclk_i) disable iff (reset_i)
         is_lock |=> ((locked_r | $past(mask_i)) == 8'hff);
   endproperty
   a_lock_sets: assert property (p_lock_sets) else $error("Lock code missed a group.");

   // Unlock code clears every unmasked group.
   property p_unlock_clears;
      @(posedge mclk_i) disable iff (reset_i)
         is_unlock |=> ((locked_r & ~$past(mask_i)) == 8'h00);
   endproperty
   a_unlock_clears: assert property (p_unlock_clears) else $error("Unlock code missed a group.");

   // Any other code leaves the state alone.
   property p_other_code;
      @(posedge mclk_i) disable iff (reset_i)
         (key_wr_i && !is_lock && !is_unlock) |=> $stable(locked_r);
   endproperty
   a_other_code: assert property (p_other_code) else $error("Unknown key code changed lock state.");
endmodule

// File: rcl_regs.sv
/*
 * Buck mode and lock mask register bank with lock key handling.
 * Assumes the serial bus engine presents single-cycle read and write strobes
 * with an 8-bit register address, synchronous to mclk_i.
 */
`timescale 1ns/10ps
// Summary of operation
// - Bits 7 and 6 force discontinuous conduction on buck two and buck one.
// - Bits 5..3 pick 500mA or 1000mA transition valley current, bucks three..one.
// - Bits 2..0 pick high or low loop bandwidth, bucks three..one.
// - Mask bits 7..0: LDO two, LDO one, buck-boost, boost, bucks three..one, charger.
// - A set mask bit keeps its group out of locking and unlocking.
// - Key 0x55 unlocks, 0xaa locks unmasked groups; other codes do nothing.
// - Reading the key register returns per-group lock state, 1 meaning locked.
module rcl_regs (
   input  wire logic                    mclk_i,
   input  wire logic                    reset_i,
   input  wire rcl_pkg::rcl_req_t       req_i,
   output logic                    [7:0] rdata_o,
   output logic                         rvalid_o,
   output rcl_pkg::rcl_buck_ctrl_t      buck_ctrl_o,
   output logic                    [7:0] locked_o
);
   logic [7:0] buck_cfg_r;
   logic [7:0] buck_cfg_nxt;
   logic [7:0] mask_r;
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;
   logic       rvalid_r;
   logic [7:0] locked;

   // ***************************************************************
   // Address decode.
   // ***************************************************************
   wire sel_buck = (req_i.addr == rcl_pkg::BUCK_MODE_CONFIG_ADDR);
   wire sel_mask = (req_i.addr == rcl_pkg::LOCK_GROUP_MASK_ADDR);
   wire sel_key  = (req_i.addr == rcl_pkg::LOCK_KEY_ADDR);
   wire key_wr   = req_i.wr && sel_key;

   // Each buck field is guarded by its own buck's lock flag, so a locked
   // buck keeps its bits while its neighbours in the same byte still change.
   wire b1_lk = locked[rcl_pkg::BUCK_ONE_MASK_BIT];
   wire b2_lk = locked[rcl_pkg::BUCK_TWO_MASK_BIT];
   wire b3_lk = locked[rcl_pkg::BUCK_THREE_MASK_BIT];
   wire [7:0] buck_wr_en = {~b2_lk, ~b1_lk, ~b3_lk, ~b2_lk, ~b1_lk, ~b3_lk, ~b2_lk, ~b1_lk};

   assign buck_cfg_nxt = (req_i.wr && sel_buck) ?
                         ((req_i.wdata & buck_wr_en) | (buck_cfg_r & ~buck_wr_en)) : buck_cfg_r;

   // Read mux; unmapped addresses read as zero.
   assign rdata_nxt = sel_buck ? buck_cfg_r :
                      sel_mask ? mask_r :
                      sel_key  ? locked :
                      8'h00;

   // ***************************************************************
   // Registers.
   // ***************************************************************
   // Mask itself is not part of any group, so it is always writable.
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         buck_cfg_r <= rcl_pkg::BUCK_MODE_CONFIG_RST;
         mask_r     <= rcl_pkg::LOCK_GROUP_MASK_RST;
      end else begin
         buck_cfg_r <= buck_cfg_nxt;
         if (req_i.wr && sel_mask) begin
            mask_r <= req_i.wdata;
         end
      end
   end

   // Read data is registered one cycle after the read strobe.
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         rdata_r  <= 8'h00;
         rvalid_r <= 1'b0;
      end else begin
         rvalid_r <= req_i.rd;
         if (req_i.rd) begin
            rdata_r <= rdata_nxt;
         end
      end
   end

   rcl_lock_state u_lock (
      .mclk_i   (mclk_i),
      .reset_i  (reset_i),
      .key_wr_i (key_wr),
      .key_i    (req_i.wdata),
      .mask_i   (mask_r),
      .locked_o (locked)
   );

   // ***************************************************************
   // Outputs to the converters.
   // ***************************************************************
   // Forced discontinuous mode is only safe at light load; hardware cannot
   // check the load, so software owns that decision.
   assign buck_ctrl_o.forced_discontinuous = {buck_cfg_r[rcl_pkg::BUCK_TWO_FORCED_DISCONTINUOUS_BIT],
                                              buck_cfg_r[rcl_pkg::BUCK_ONE_FORCED_DISCONTINUOUS_BIT]};
   assign buck_ctrl_o.valley_current_high  = {buck_cfg_r[rcl_pkg::BUCK_THREE_TRANSITION_VALLEY_CURRENT_BIT],
                                              buck_cfg_r[rcl_pkg::BUCK_TWO_TRANSITION_VALLEY_CURRENT_BIT],
                                              buck_cfg_r[rcl_pkg::BUCK_ONE_TRANSITION_VALLEY_CURRENT_BIT]};
   assign buck_ctrl_o.narrow_loop          = {buck_cfg_r[rcl_pkg::BUCK_THREE_NARROW_LOOP_BIT],
                                              buck_cfg_r[rcl_pkg::BUCK_TWO_NARROW_LOOP_BIT],
                                              buck_cfg_r[rcl_pkg::BUCK_ONE_NARROW_LOOP_BIT]};
   assign rdata_o  = rdata_r;
   assign rvalid_o = rvalid_r;
   assign locked_o = locked;

   // ***************************************************************
   // Checks.
   // ***************************************************************
   property p_dcm_map;
      @(posedge mclk_i) disable iff (reset_i)
         (req_i.wr && sel_buck && !b1_lk && !b2_lk) |=>
            (buck_ctrl_o.forced_discontinuous == $past(req_i.wdata[7:6]));
   endproperty
   a_dcm_map: assert property (p_dcm_map) else $error("Forced DCM bits not mapped.");

   property p_valley_map;
      @(posedge mclk_i) disable iff (reset_i)
         (req_i.wr && sel_buck && !b1_lk && !b2_lk && !b3_lk) |=>
            (buck_ctrl_o.valley_current_high == $past(req_i.wdata[5:3]));
   endproperty
   a_valley_map: assert property (p_valley_map) else $error("Valley current bits not mapped.");

   property p_loop_map;
      @(posedge mclk_i) disable iff (reset_i)
         (req_i.wr && sel_buck && !b1_lk && !b2_lk && !b3_lk) |=>
            (buck_ctrl_o.narrow_loop == $past(req_i.wdata[2:0]));
   endproperty
   a_loop_map: assert property (p_loop_map) else $error("Loop bandwidth bits not mapped.");

   property p_mask_write;
      @(posedge mclk_i) disable iff (reset_i)
         (req_i.wr && sel_mask) |=> (mask_r == $past(req_i.wdata));
   endproperty
   a_mask_write: assert property (p_mask_write) else $error("Mask write lost.");

   property p_key_read;
      @(posedge mclk_i) disable iff (reset_i)
         (req_i.rd && sel_key) |=> (rvalid_o && rdata_o == $past(locked));
   endproperty
   a_key_read: assert property (p_key_read) else $error("Key read not lock state.");

   property p_locked_hold;
      @(posedge mclk_i) disable iff (reset_i)
         (b1_lk && b2_lk && b3_lk) |=> $stable(buck_cfg_r);
   endproperty
   a_locked_hold: assert property (p_locked_hold) else $error("Locked buck config changed.");

   // ***************************************************************
   // Per-converter lock checks.
   // ***************************************************************
   // A locked buck one keeps its three bits even when its neighbours take the write.
   property p_buck_one_keep;
      @(posedge mclk_i) disable iff (reset_i)
         (req_i.wr && sel_buck && b1_lk) |=>
            ($stable(buck_ctrl_o.forced_discontinuous[0]) && $stable(buck_ctrl_o.valley_current_high[0]) &&
             $stable(buck_ctrl_o.narrow_loop[0]));
   endproperty
   a_buck_one_keep: assert property (p_buck_one_keep) else $error("Locked buck one bits changed.");

   // A locked buck two keeps its three bits even when its neighbours take the write.
   property p_buck_two_keep;
      @(posedge mclk_i) disable iff (reset_i)
         (req_i.wr && sel_buck && b2_lk) |=>
            ($stable(buck_ctrl_o.forced_discontinuous[1]) && $stable(buck_ctrl_o.valley_current_high[1]) &&
             $stable(buck_ctrl_o.narrow_loop[1]));
   endproperty
   a_buck_two_keep: assert property (p_buck_two_keep) else $error("Locked buck two bits changed.");

   // Buck three has no forced discontinuous bit, so only two bits are guarded.
   property p_buck_three_keep;
      @(posedge mclk_i) disable iff (reset_i)
         (req_i.wr && sel_buck && b3_lk) |=>
            ($stable(buck_ctrl_o.valley_current_high[2]) && $stable(buck_ctrl_o.narrow_loop[2]));
   endproperty
   a_buck_three_keep: assert property (p_buck_three_keep) else $error("Locked buck three bits changed.");

   // An unlocked buck one takes its bits from the write, whatever its neighbours' locks.
   property p_buck_one_take;
      @(posedge mclk_i) disable iff (reset_i)
         (req_i.wr && sel_buck && !b1_lk) |=>
            ((buck_ctrl_o.forced_discontinuous[0] ==
              $past(req_i.wdata[rcl_pkg::BUCK_ONE_FORCED_DISCONTINUOUS_BIT])) &&
             (buck_ctrl_o.valley_current_high[0] ==
              $past(req_i.wdata[rcl_pkg::BUCK_ONE_TRANSITION_VALLEY_CURRENT_BIT])) &&
             (buck_ctrl_o.narrow_loop[0] ==
              $past(req_i.wdata[rcl_pkg::BUCK_ONE_NARROW_LOOP_BIT])));
   endproperty
   a_buck_one_take: assert property (p_buck_one_take) else $error("Unlocked buck one bits not written.");

   // An unlocked buck two takes its bits from the write, whatever its neighbours' locks.
   property p_buck_two_take;
      @(posedge mclk_i) disable iff (reset_i)
         (req_i.wr && sel_buck && !b2_lk) |=>
            ((buck_ctrl_o.forced_discontinuous[1] ==
              $past(req_i.wdata[rcl_pkg::BUCK_TWO_FORCED_DISCONTINUOUS_BIT])) &&
             (buck_ctrl_o.valley_current_high[1] ==
              $past(req_i.wdata[rcl_pkg::BUCK_TWO_TRANSITION_VALLEY_CURRENT_BIT])) &&
             (buck_ctrl_o.narrow_loop[1] ==
              $past(req_i.wdata[rcl_pkg::BUCK_TWO_NARROW_LOOP_BIT])));
   endproperty
   a_buck_two_take: assert property (p_buck_two_take) else $error("Unlocked buck two bits not written.");

   // An unlocked buck three takes its two bits from the write.
   property p_buck_three_take;
      @(posedge mclk_i) disable iff (reset_i)
         (req_i.wr && sel_buck && !b3_lk) |=>
            ((buck_ctrl_o.valley_current_high[2] ==
              $past(req_i.wdata[rcl_pkg::BUCK_THREE_TRANSITION_VALLEY_CURRENT_BIT])) &&
             (buck_ctrl_o.narrow_loop[2] ==
              $past(req_i.wdata[rcl_pkg::BUCK_THREE_NARROW_LOOP_BIT])));
   endproperty
   a_buck_three_take: assert property (p_buck_three_take) else $error("Unlocked buck three bits not written.");

   // ***************************************************************
   // Read port checks.
   // ***************************************************************
   // Every read strobe is answered by a valid pulse on the next cycle.
   property p_read_answer;
      @(posedge mclk_i) disable iff (reset_i)
         req_i.rd |=> rvalid_o;
   endproperty
   a_read_answer: assert property (p_read_answer) else $error("Read strobe not answered.");

   // Without a strobe the valid flag stays low and the read data holds, so a slow host can still pick it up.
   property p_read_idle;
      @(posedge mclk_i) disable iff (reset_i)
         !req_i.rd |=> (!rvalid_o && $stable(rdata_o));
   endproperty
   a_read_idle: assert property (p_read_idle) else $error("Read port moved without a strobe.");

   // Reading the buck register returns what is stored, locked or not.
   property p_cfg_read;
      @(posedge mclk_i) disable iff (reset_i)
         (req_i.rd && sel_buck) |=> (rdata_o == $past(buck_cfg_r));
   endproperty
   a_cfg_read: assert property (p_cfg_read) else $error("Buck register read wrong.");

   // Reading the mask register returns the stored mask.
   property p_mask_read;
      @(posedge mclk_i) disable iff (reset_i)
         (req_i.rd && sel_mask) |=> (rdata_o == $past(mask_r));
   endproperty
   a_mask_read: assert property (p_mask_read) else $error("Mask register read wrong.");

   // The mask moves only on a write to its own address; a stray change would silently unguard a group.
   property p_mask_keep;
      @(posedge mclk_i) disable iff (reset_i)
         !(req_i.wr && sel_mask) |=> $stable(mask_r);
   endproperty
   a_mask_keep: assert property (p_mask_keep) else $error("Mask changed without a write.");
endmodule

// File: rcl_regs_tb_top.sv
/*
 * Self-checking testbench for the buck mode and lock mask register bank.
 * Assumes the bank answers reads one cycle after the strobe edge and applies writes at that edge.
 */
`timescale 1ns/10ps
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin err_total++; \
   $display("ERROR t=%0t got %h exp %h", $time, (got), (exp)); end end
module rcl_regs_tb_top;
   // ***************************************************************
   // Stimulus and observation signals.
   // ***************************************************************
   logic                    mclk_i          = 1'b0;
   logic                    reset_i         = 1'b1;
   rcl_pkg::rcl_req_t       req             = '0;
   logic [7:0]              rdata_o;
   logic                    rvalid_o;
   rcl_pkg::rcl_buck_ctrl_t buck_ctrl_o;
   logic [7:0]              locked_o;
   logic [7:0]              rv;
   int                      err_total       = 0;
   int                      samples_checked = 0;
   int                      cycles          = 0;

   rcl_regs dut (
      .mclk_i      (mclk_i),
      .reset_i     (reset_i),
      .req_i       (req),
      .rdata_o     (rdata_o),
      .rvalid_o    (rvalid_o),
      .buck_ctrl_o (buck_ctrl_o),
      .locked_o    (locked_o)
   );

   // The clock toggles every 5 ns, half of its 10 ns period.
   always #5 mclk_i = ~mclk_i;

   // A hang is cut short well past the roughly 110 cycles the tests need.
   always @(posedge mclk_i) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         err_total++;
         tally_and_finish();
      end
   end

   // ***************************************************************
   // Register port tasks.
   // ***************************************************************
   // The strobe is lowered at the edge that takes it, so one idle edge separates transfers.
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk_i);
      req <= {1'b1, 1'b0, a, d};
      @(posedge mclk_i);
      req.wr <= 1'b0;
      #1;
   endtask

   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge mclk_i);
      req <= {1'b0, 1'b1, a, 8'h00};
      @(posedge mclk_i);
      req.rd <= 1'b0;
      #1;
      `CHK(rvalid_o, 1'b1)
      d = rdata_o;
   endtask

   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   // ***************************************************************
   // Scenarios.
   // ***************************************************************
   // Reset is held for eight edges, then the converter and lock outputs and all three registers must read zero.
   task automatic t_reset();
      @(posedge mclk_i);
      reset_i <= 1'b1;
      repeat (8) @(posedge mclk_i);
      reset_i <= 1'b0;
      #1;
      `CHK({buck_ctrl_o, locked_o}, 16'h0000)
      rd_reg(8'h81, rv); `CHK(rv, 8'h00)
      rd_reg(8'h83, rv); `CHK(rv, 8'h00)
      rd_reg(8'h84, rv); `CHK(rv, 8'h00)
      $display("reset test done");
   endtask

   // A walking one shows that each bit steers exactly its own converter field.
   task automatic t_buck_fields();
      logic [7:0] v;
      for (int i = 0; i < 8; i++) begin
         v = 8'h01 << i;
         wr_reg(8'h81, v);
         `CHK(buck_ctrl_o.forced_discontinuous, {v[7], v[6]})
         `CHK(buck_ctrl_o.valley_current_high, {v[5], v[4], v[3]})
         `CHK(buck_ctrl_o.narrow_loop, {v[2], v[1], v[0]})
         rd_reg(8'h81, rv); `CHK(rv, v)
      end
      wr_reg(8'h81, 8'h00);
      $display("buck field test done");
   endtask

   // Masked groups keep their state; locked bucks keep their bits per converter.
   task automatic t_lock();
      wr_reg(8'h83, 8'h04);
      rd_reg(8'h83, rv); `CHK(rv, 8'h04)
      wr_reg(8'h84, 8'haa);
      `CHK(locked_o, 8'hfb)
      rd_reg(8'h84, rv); `CHK(rv, 8'hfb)
      wr_reg(8'h84, 8'h3c);
      `CHK(locked_o, 8'hfb)
      wr_reg(8'h81, 8'hff);
      `CHK(buck_ctrl_o, 8'h92)
      rd_reg(8'h81, rv); `CHK(rv, 8'h92)
      wr_reg(8'h83, 8'h01);
      wr_reg(8'h84, 8'h55);
      `CHK(locked_o, 8'h01)
      wr_reg(8'h81, 8'hff);
      `CHK(buck_ctrl_o, 8'hff)
      wr_reg(8'h83, 8'hff);
      wr_reg(8'h84, 8'haa);
      `CHK(locked_o, 8'h01)
      rd_reg(8'h84, rv); `CHK(rv, 8'h01)
      // All groups locked: the whole buck byte ignores a write.
      wr_reg(8'h83, 8'h00);
      wr_reg(8'h84, 8'haa);
      `CHK(locked_o, 8'hff)
      wr_reg(8'h81, 8'h00);
      rd_reg(8'h81, rv); `CHK(rv, 8'hff)
      // Only buck two stays locked, so bits 7, 4 and 1 keep their ones.
      wr_reg(8'h83, 8'h04);
      wr_reg(8'h84, 8'h55);
      `CHK(locked_o, 8'h04)
      wr_reg(8'h81, 8'h00);
      `CHK(buck_ctrl_o, 8'h92)
      $display("lock test done");
   endtask

   // An unmapped address reads zero and a write there disturbs nothing.
   task automatic t_unmapped();
      rd_reg(8'h82, rv); `CHK(rv, 8'h00)
      wr_reg(8'h82, 8'h00);
      rd_reg(8'h81, rv); `CHK(rv, 8'h92)
      rd_reg(8'h83, rv); `CHK(rv, 8'h04)
      $display("unmapped test done");
   endtask

   // Main sequence, ending with a reset in mid-run.
   initial begin
      t_reset();
      t_buck_fields();
      t_lock();
      t_unmapped();
      t_reset();
      tally_and_finish();
   end
endmodule
